/* rtl/pbsp_top.sv */
/*
 * Pipelined burst SRAM access port: input registers, two-bit burst
 * counter, self-timed byte writes through a write buffer, pipelined
 * reads with a registered output stage.
 * Assumes the host drives every synchronous input from logic on mclk
 * and respects wbuf_ready before issuing writes.
 */
`default_nettype none

// Overview of operation
// (R1) Array is 256K x 36 or 512K x 18, chosen by parameters.
// (R2) All synchronous inputs are registered on the rising clock edge.
// (R3) Inputs include one pipelined and two depth-expansion chip enables.
// (R4) Address and chip-enable state load only when a strobe is active.
// (R5) Later burst addresses are generated inside, stepping on advance.
// (R6) The burst counter is two bits wide, four locations per burst.
// (R7) A static input selects linear or interleaved burst order.
// (R8) Writes complete internally from registered address, data, controls.
// (R9) Byte selects allow writing one, two or all bytes.
// (R10) Global write low writes every byte lane.
// (R11) Output enable and sleep act outside the synchronous input path.
// (R12) Inputs and outputs are registered; read data follows its address.
// (R13) Four-word burst runs three cycles, then one per word.
// (R14) Deselect takes effect within one cycle of being sampled.
// (R15) Host never clocks the bus above the supported maximum.
// (R16) The two low address bits seed the burst counter on load.
// (R17) Byte selects act only when qualified by byte write enable.
// (R18) Host drives byte write enable low for byte-selective writes.
// (R19) Global write overrides byte selects and byte write enable.
// (R20) Linear adds step modulo four; interleaved xors seed with step.
// (R21) Output enable off floats data outputs regardless of pipeline.

module pbsp_top
   import pbsp_pkg::*;
#(
   parameter int ADDR_W = PBSP_ADDR_W,
   parameter int BYTES = PBSP_BYTES,
   parameter int BYTE_W = PBSP_BYTE_W,
   parameter int WBUF_DEPTH = PBSP_WBUF_DEPTH
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Address and strobes
   input wire logic [ADDR_W-1:0] addr,
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic burst_advance_n,
   // Chip enables
   input wire logic pipelined_chip_enable_n,
   input wire logic depth_chip_enable_hi,
   input wire logic depth_chip_enable_lo_n,
   // Write controls
   input wire logic [BYTES-1:0] byte_write_select_n,
   input wire logic byte_write_enable_n,
   input wire logic global_write_n,
   // Static and asynchronous controls
   input wire logic burst_order_linear,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   // Data pins, split three ways
   input wire logic [BYTES*BYTE_W-1:0] data_in,
   output logic [BYTES*BYTE_W-1:0] data_out,
   output logic data_oe,
   // Write buffer has room
   output logic wbuf_ready
);

   localparam int DATA_W = BYTES * BYTE_W;
   localparam int WORDS = 1 << ADDR_W;
   localparam int ENTRY_W = ADDR_W + BYTES + DATA_W;
   localparam int LVL_W = $clog2(WBUF_DEPTH+1);
   localparam int HI_W = ADDR_W - PBSP_BURST_W;
   localparam logic [LVL_W-1:0] ROOM_MAX =
      LVL_W'(WBUF_DEPTH - PBSP_WBUF_SLACK);

   // Array; ninth bit of each lane is its parity lane
   logic [DATA_W-1:0] mem [0:WORDS-1]; // (R1)

   // Input registers
   logic [ADDR_W-1:0] addr_reg;
   logic proc_strobe_n_reg;
   logic ctrl_strobe_n_reg;
   logic advance_n_reg;
   logic ce_pipe_n_reg;
   logic ce_hi_reg;
   logic ce_lo_n_reg;
   logic [BYTES-1:0] bws_n_reg;
   logic bwe_n_reg;
   logic gw_n_reg;
   logic [DATA_W-1:0] din_reg;

   // Synchronisers for pins outside the synchronous set
   logic oe_n_meta;
   logic oe_n_sync;
   logic sleep_meta;
   logic sleep_sync;
   logic order_meta;
   logic order_sync;

   // Burst state
   pbsp_cyc_t cyc_reg;
   logic [HI_W-1:0] base_reg;
   logic [PBSP_BURST_W-1:0] seed_reg;
   logic [PBSP_BURST_W-1:0] step_reg;

   // Read pipeline and outputs
   logic [DATA_W-1:0] rdata_reg;
   logic rvalid_reg;
   logic [DATA_W-1:0] data_out_reg;
   logic data_oe_reg;
   logic wbuf_ready_reg;

   // Decode
   logic proc_load;
   logic ctrl_load;
   logic load;
   logic selected;
   logic cont;
   logic access;
   logic is_write;
   logic [BYTES-1:0] wmask;
   logic [HI_W-1:0] base_cur;
   logic [PBSP_BURST_W-1:0] seed_cur;
   logic [PBSP_BURST_W-1:0] step_next;
   logic [PBSP_BURST_W-1:0] offset;
   logic [ADDR_W-1:0] acc_addr;

   // Write buffer
   logic [LVL_W-1:0] wbuf_level;
   logic [ADDR_W-1:0] drain_addr;
   logic [BYTES-1:0] drain_mask;
   logic [DATA_W-1:0] drain_data;

   pbsp_stream_if #(.W(ENTRY_W)) wq_in ();
   pbsp_stream_if #(.W(ENTRY_W)) wq_out ();

   // Every synchronous pin captured on the rising edge
   always_ff @(posedge mclk) begin
      addr_reg <= addr; // (R2)
      proc_strobe_n_reg <= processor_addr_strobe_n;
      ctrl_strobe_n_reg <= controller_addr_strobe_n;
      advance_n_reg <= burst_advance_n;
      ce_pipe_n_reg <= pipelined_chip_enable_n; // (R3)
      ce_hi_reg <= depth_chip_enable_hi;
      ce_lo_n_reg <= depth_chip_enable_lo_n;
      bws_n_reg <= byte_write_select_n;
      bwe_n_reg <= byte_write_enable_n;
      gw_n_reg <= global_write_n;
      din_reg <= data_in;
   end

   // Two flops each; only the second is read by logic
   always_ff @(posedge mclk) begin
      oe_n_meta <= output_enable_n; // (R11)
      oe_n_sync <= oe_n_meta;
      sleep_meta <= sleep_request;
      sleep_sync <= sleep_meta;
      order_meta <= burst_order_linear;
      order_sync <= order_meta;
   end

   // Processor strobe is ignored while the pipelined enable is off
   assign proc_load = !proc_strobe_n_reg && !ce_pipe_n_reg;
   assign ctrl_load = !ctrl_strobe_n_reg;
   assign load = (proc_load || ctrl_load) && !sleep_sync; // (R4)
   assign selected = !ce_pipe_n_reg && ce_hi_reg && !ce_lo_n_reg;
   assign cont = !load && !sleep_sync && (cyc_reg == CYC_BURST);
   assign access = (load && selected) || cont;

   // Lane mask: global write beats the qualified byte selects
   always_comb begin
      if (!gw_n_reg) begin
         wmask = '1; // (R10) (R19)
      end else if (!bwe_n_reg) begin
         wmask = ~bws_n_reg; // (R9) (R17)
      end else begin
         wmask = '0;
      end
   end

   // A processor-strobe load is always a read cycle
   assign is_write = access && (wmask != '0) && !(load && proc_load);

   // Next burst address from seed and step
   always_comb begin
      base_cur = base_reg;
      seed_cur = seed_reg;
      step_next = step_reg;
      if (load) begin
         base_cur = addr_reg[ADDR_W-1:PBSP_BURST_W];
         seed_cur = addr_reg[PBSP_BURST_W-1:0]; // (R16)
         step_next = PBSP_STEP_RST;
      end else if (cont && !advance_n_reg) begin
         step_next = step_reg + PBSP_STEP_INC; // (R5) (R6)
      end
      if (order_sync) begin
         offset = seed_cur + step_next; // (R7) (R20)
      end else begin
         offset = seed_cur ^ step_next; // (R20)
      end
      acc_addr = {base_cur, offset};
   end

   // Port state: a deselecting load ends the burst at once
   always_ff @(posedge mclk) begin
      if (rst) begin
         cyc_reg <= CYC_IDLE;
      end else begin
         case (cyc_reg)
            CYC_IDLE: begin
               if (load && selected) begin
                  cyc_reg <= CYC_BURST;
               end
            end
            CYC_BURST: begin
               if (sleep_sync || (load && !selected)) begin
                  cyc_reg <= CYC_IDLE; // (R14)
               end
            end
            default: begin
               cyc_reg <= CYC_IDLE;
            end
         endcase
      end
   end

   // Burst counter registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         base_reg <= '0;
         seed_reg <= PBSP_STEP_RST;
         step_reg <= PBSP_STEP_RST;
      end else if (load || cont) begin
         base_reg <= base_cur;
         seed_reg <= seed_cur;
         step_reg <= step_next;
      end
   end

   // Writes queue up so the array accepts them without host timing
   assign wq_in.valid = is_write; // (R8)
   assign wq_in.data = {acc_addr, wmask, din_reg};

   pbsp_fifo #(
      .W(ENTRY_W),
      .DEPTH(WBUF_DEPTH)
   ) u_wbuf (
      .mclk(mclk),
      .rst(rst),
      .in_s(wq_in),
      .out_s(wq_out),
      .level(wbuf_level)
   );

   // Array is parked during sleep, so the buffer really fills
   assign wq_out.ready = !sleep_sync;
   assign drain_addr = wq_out.data[ENTRY_W-1 -: ADDR_W];
   assign drain_mask = wq_out.data[DATA_W +: BYTES];
   assign drain_data = wq_out.data[DATA_W-1:0];

   // Self-timed write port, lane by lane
   always_ff @(posedge mclk) begin
      if (wq_out.valid && wq_out.ready) begin
         for (int b = 0; b < BYTES; b++) begin
            if (drain_mask[b]) begin
               mem[drain_addr][b*BYTE_W +: BYTE_W] <=
                  drain_data[b*BYTE_W +: BYTE_W]; // (R8) (R9)
            end
         end
      end
   end

   // Read stage: array word one edge after the input registers
   always_ff @(posedge mclk) begin
      if (access && !is_write) begin
         rdata_reg <= mem[acc_addr]; // (R12) (R13)
      end
   end

   // Read-valid marker; clears on deselect, writes and sleep
   always_ff @(posedge mclk) begin
      if (rst) begin
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= access && !is_write; // (R14)
      end
   end

   // Output stage; enable gates the drive, never the pipeline
   always_ff @(posedge mclk) begin
      if (rst) begin
         data_out_reg <= '0;
         data_oe_reg <= 1'b0;
      end else begin
         data_out_reg <= rdata_reg; // (R12) (R13)
         data_oe_reg <= rvalid_reg && !oe_n_sync && !sleep_sync; // (R21)
      end
   end

   // Room flag keeps slack for writes already in the input stages
   always_ff @(posedge mclk) begin
      if (rst) begin
         wbuf_ready_reg <= 1'b0;
      end else begin
         wbuf_ready_reg <= (wbuf_level <= ROOM_MAX);
      end
   end

   assign data_out = data_out_reg;
   assign data_oe = data_oe_reg;
   assign wbuf_ready = wbuf_ready_reg;

endmodule : pbsp_top

`default_nettype wire

/* rtl/pbsp_pkg.sv */
/*
 * Shared constants and types of the pipelined burst SRAM access port.
 * Assumes one 10 MHz clock and a host synchronous to it.
 */
`default_nettype none

package pbsp_pkg;

   // Array shape, wide variant (256K words of 36 bits)
   localparam int PBSP_BYTE_W = 9;
   localparam int PBSP_BYTES = 4;
   localparam int PBSP_ADDR_W = 18;

   // Array shape, narrow variant (512K words of 18 bits)
   localparam int PBSP_NARROW_BYTES = 2;
   localparam int PBSP_NARROW_ADDR_W = 19;

   // Burst counter
   localparam int PBSP_BURST_W = 2;
   localparam logic [1:0] PBSP_STEP_RST = 2'h0;
   localparam logic [1:0] PBSP_STEP_INC = 2'h1;

   // Write buffer: depth, and room kept for writes already in flight
   localparam int PBSP_WBUF_DEPTH = 16;
   localparam int PBSP_WBUF_SLACK = 3;

   // Clocking: bus ceiling the host must respect, and our own rate
   localparam int PBSP_MAX_BUS_MHZ = 200;
   localparam int PBSP_CLK_MHZ = 10;

   // Pipeline depth from address edge to data edge (first word)
   localparam int PBSP_FIRST_WORD_CYC = 3;

   // Port state: deselected or inside a burst
   typedef enum logic {
      CYC_IDLE,
      CYC_BURST
   } pbsp_cyc_t;

endpackage : pbsp_pkg

`default_nettype wire

/* rtl/pbsp_stream_if.sv */
/*
 * Valid/ready word stream between the port and its write buffer.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface pbsp_stream_if #(
   parameter int W = 8
) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;

   // Producer end
   modport src (output valid, output data, input ready);
   // Consumer end
   modport snk (input valid, input data, output ready);
endinterface : pbsp_stream_if

`default_nettype wire

/* rtl/pbsp_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides and a fill level.
 * Assumes one clock and a synchronous active-high reset.
 */
`default_nettype none

module pbsp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Fill side and drain side
   pbsp_stream_if.snk in_s,
   pbsp_stream_if.src out_s,
   // Words held
   output logic [$clog2(DEPTH+1)-1:0] level
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);

   logic [W-1:0] store [0:DEPTH-1];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic push;
   logic pop;

   // Honest flags straight from the count
   assign in_s.ready = (count_reg != CW'(DEPTH));
   assign out_s.valid = (count_reg != '0);
   assign out_s.data = store[rd_ptr_reg];
   assign level = count_reg;
   assign push = in_s.valid & in_s.ready;
   assign pop = out_s.valid & out_s.ready;

   // Storage, no reset needed
   always_ff @(posedge mclk) begin
      if (push) begin
         store[wr_ptr_reg] <= in_s.data;
      end
   end

   // Pointers wrap at DEPTH, so any depth works
   always_ff @(posedge mclk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 :
               wr_ptr_reg + PW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 :
               rd_ptr_reg + PW'(1);
         end
      end
   end

   // Occupancy
   always_ff @(posedge mclk) begin
      if (rst) begin
         count_reg <= '0;
      end else if (push && !pop) begin
         count_reg <= count_reg + CW'(1);
      end else if (pop && !push) begin
         count_reg <= count_reg - CW'(1);
      end
   end

endmodule : pbsp_fifo

`default_nettype wire

/* bench/pbsp_port_monitor.sv */
/* Checker for the burst SRAM port, bound to pbsp_top.
   Assumes the host changes pins only at the falling clock edge. */
`default_nettype none

module pbsp_port_monitor #(
   parameter int BYTES = 4,
   parameter int BYTE_W = 9
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Bus controls
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic pipelined_chip_enable_n,
   input wire logic depth_chip_enable_hi,
   input wire logic depth_chip_enable_lo_n,
   input wire logic [BYTES-1:0] byte_write_select_n,
   input wire logic byte_write_enable_n,
   input wire logic global_write_n,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   // Outputs watched
   input wire logic [BYTES*BYTE_W-1:0] data_out,
   input wire logic data_oe,
   input wire logic wbuf_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Decoded bus cycle; sync flops mean quiet must hold three edges
   wire logic sel = !pipelined_chip_enable_n && depth_chip_enable_hi &&
      !depth_chip_enable_lo_n;
   wire logic wr = !global_write_n ||
      (!byte_write_enable_n && !(&byte_write_select_n));
   wire logic quiet = !sleep_request && !output_enable_n;
   wire logic c_ld = !controller_addr_strobe_n && quiet;
   wire logic cont = processor_addr_strobe_n && controller_addr_strobe_n;

   rst_clear_a: assert property (disable iff (1'b0)
      rst |=> !data_oe && !wbuf_ready && data_out == '0)
      else $error("outputs not cleared by reset");
   ready_rise_a: assert property ($fell(rst) |=> wbuf_ready)
      else $error("write buffer not ready after reset");
   oe_float_a: assert property (output_enable_n[*3] |=> !data_oe)
      else $error("data driven with output enable off");
   deselect_a: assert property ((c_ld && !sel) |-> ##3 !data_oe)
      else $error("data driven after deselect");
   read_lat_a: assert property (quiet[*3] ##0 (c_ld && sel && !wr)
      |-> ##3 data_oe) else $error("read data late or missing");
   proc_read_a: assert property (quiet[*3] ##0 (!processor_addr_strobe_n
      && controller_addr_strobe_n && sel && !global_write_n) |-> ##3 data_oe)
      else $error("processor strobe load not a read");
   burst_step_a: assert property (quiet[*3] ##0 (c_ld && sel && !wr)
      ##1 (quiet && cont && !burst_advance_n && !wr) |-> ##3 data_oe)
      else $error("burst continue gave no data");
   // Processor-strobe loads are always reads, so only controller loads count
   write_quiet_a: assert property ((c_ld && processor_addr_strobe_n
      && sel && wr) |-> ##3 !data_oe) else $error("write cycle drove data");

   // Main scenarios reached
   cover property (c_ld && sel && !wr ##1 (!burst_advance_n)[*3]);
   cover property (c_ld && sel && wr);
   cover property (c_ld && !sel);
endmodule : pbsp_port_monitor

`default_nettype wire

/* bench/pbsp_host_model.sv */
/* Host model driving the synchronous SRAM bus pins of the port.
   Assumes a single clock; pins change at its falling edge only. */
`default_nettype none

module pbsp_host_model (
   // Clock and buffer room
   input wire logic mclk,
   input wire logic wbuf_ready,
   // Bus pins
   output logic [17:0] addr,
   output logic processor_addr_strobe_n,
   output logic controller_addr_strobe_n,
   output logic burst_advance_n,
   output logic pipelined_chip_enable_n,
   output logic depth_chip_enable_hi,
   output logic depth_chip_enable_lo_n,
   output logic [3:0] byte_write_select_n,
   output logic byte_write_enable_n,
   output logic global_write_n,
   output logic [35:0] data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus; the one chip enable without a scenario stays on
   initial begin
      {processor_addr_strobe_n, controller_addr_strobe_n} = 2'h3;
      burst_advance_n = 1'b1;
      pipelined_chip_enable_n = 1'b0;
      depth_chip_enable_hi = 1'b1;
      depth_chip_enable_lo_n = 1'b0;
      {global_write_n, byte_write_enable_n, byte_write_select_n} = 6'h3F;
      addr = 18'h0;
      data_in = 36'h0;
   end

   // One bus cycle; w is {global, byte enable, byte selects}
   task automatic put(input logic [1:0] stb, input logic adv_n,
      input logic hi, input logic [17:0] a, input logic [5:0] w,
      input logic [35:0] d);
      @(negedge mclk);
      while (w[5:4] != 2'h3 && !wbuf_ready) @(negedge mclk);
      {processor_addr_strobe_n, controller_addr_strobe_n} = stb;
      burst_advance_n = adv_n;
      depth_chip_enable_hi = hi;
      addr = a;
      {global_write_n, byte_write_enable_n, byte_write_select_n} = w;
      data_in = d;
   endtask : put

   // Pipelined enable is static; only this model drives it
   task automatic hold_pipe_ce(input logic ce_n);
      pipelined_chip_enable_n = ce_n;
   endtask : hold_pipe_ce

   // Released pins flip so stale values never pass for fresh ones
   task automatic park();
      put(2'h3, 1'b1, 1'b1, ~addr, 6'h3F, ~data_in);
   endtask : park
endmodule : pbsp_host_model

`default_nettype wire

/* bench/testbench.sv */
/* Self-checking bench for the burst SRAM port with a host model.
   Assumes a 10 MHz clock and the default 256K x 36 shape. */
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic burst_order_linear = 1'b0;
   logic output_enable_n = 1'b0;
   logic sleep_request = 1'b0;
   logic [17:0] addr;
   logic processor_addr_strobe_n, controller_addr_strobe_n;
   logic burst_advance_n, pipelined_chip_enable_n;
   logic depth_chip_enable_hi, depth_chip_enable_lo_n;
   logic [3:0] byte_write_select_n;
   logic byte_write_enable_n, global_write_n;
   logic [35:0] data_in, data_out;
   logic data_oe, wbuf_ready;
   int errors = 0;
   int comparisons = 0;
   logic [35:0] mem_exp [0:3];

   // Clock far below the bus ceiling
   always #50 mclk = ~mclk;

   pbsp_top #(.WBUF_DEPTH(4)) i_dut (.mclk, .rst, .addr,
      .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
      .pipelined_chip_enable_n, .depth_chip_enable_hi, .depth_chip_enable_lo_n,
      .byte_write_select_n, .byte_write_enable_n, .global_write_n,
      .burst_order_linear, .output_enable_n, .sleep_request, .data_in,
      .data_out, .data_oe, .wbuf_ready);
   pbsp_host_model i_host (.mclk, .wbuf_ready, .addr,
      .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
      .pipelined_chip_enable_n, .depth_chip_enable_hi, .depth_chip_enable_lo_n,
      .byte_write_select_n, .byte_write_enable_n, .global_write_n, .data_in);

   task automatic cmp_word(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : cmp_bit

   // Write one word and update the expected image lane by lane
   task automatic wr(input logic [1:0] i, input logic [5:0] w,
      input logic [35:0] d);
      i_host.put(2'h2, 1'b1, 1'b1, {16'h0010, i}, w, d);
      i_host.park();
      for (int b = 0; b < 4; b++)
         if (!w[5] || (!w[4] && !w[b])) mem_exp[i][b*9 +: 9] = d[b*9 +: 9];
   endtask : wr

   // Burst read; data of access k is sampled three falling edges later
   task automatic rd(input logic [1:0] seed, input logic lin,
      input logic step, input int n);
      logic [1:0] off;
      fork
         begin
            i_host.put(2'h2, 1'b1, 1'b1, {16'h0010, seed}, 6'h3F, 36'h0);
            repeat (n - 1) i_host.put(2'h3, !step, 1'b1, 18'h0, 6'h3F, 36'h0);
            i_host.park();
         end
         begin
            repeat (4) @(negedge mclk);
            for (int k = 0; k < n; k++) begin
               off = lin ? 2'(seed + k * step) : seed ^ 2'(k * step);
               cmp_bit(data_oe, 1'b1);
               cmp_word(data_out, mem_exp[off]);
               @(negedge mclk);
            end
         end
      join
   endtask : rd

   // Read attempt that must leave the data pins undriven
   task automatic rd_off(input logic hi);
      i_host.put(2'h2, 1'b1, hi, 18'h00040, 6'h3F, 36'h0);
      i_host.park();
      repeat (2) @(negedge mclk);
      cmp_bit(data_oe, 1'b0);
   endtask : rd_off

   task automatic s_write;
      wr(2'h0, 6'h0F, 36'h123456789);
      wr(2'h1, 6'h0F, 36'hFEDCBA987);
      wr(2'h2, 6'h1F, 36'h0F0F0F0F0);
      wr(2'h3, 6'h0F, 36'h555555555);
      wr(2'h1, 6'h2E, 36'h000000000);
      wr(2'h3, 6'h2C, 36'hAAAAAAAAA);
      wr(2'h2, 6'h30, 36'hFFFFFFFFF);
      wr(2'h0, 6'h20, 36'h13579BDF0);
      repeat (8) @(negedge mclk);
   endtask : s_write

   task automatic s_burst;
      for (int m = 0; m < 8; m++) begin
         @(negedge mclk);
         burst_order_linear = m[2];
         repeat (4) @(negedge mclk);
         rd(m[1:0], m[2], 1'b1, 4);
      end
   endtask : s_burst

   task automatic s_proc;
      i_host.put(2'h1, 1'b1, 1'b1, 18'h00042, 6'h00, 36'hFFFFFFFFF);
      i_host.park();
      repeat (8) @(negedge mclk);
      rd(2'h2, 1'b1, 1'b0, 1);
   endtask : s_proc

   // Processor strobe with pipelined enable off must not end the burst
   task automatic s_ce_pipe;
      i_host.hold_pipe_ce(1'b1);
      i_host.put(2'h1, 1'b1, 1'b1, 18'h00040, 6'h3F, 36'h0);
      i_host.park();
      repeat (2) @(negedge mclk);
      cmp_bit(data_oe, 1'b1);
      cmp_word(data_out, mem_exp[2]);
      i_host.hold_pipe_ce(1'b0);
   endtask : s_ce_pipe

   // Sleep and output enable both pass two sync flops first
   task automatic s_async;
      @(negedge mclk);
      output_enable_n = 1'b1;
      repeat (3) @(negedge mclk);
      rd_off(1'b1);
      output_enable_n = 1'b0;
      sleep_request = 1'b1;
      repeat (3) @(negedge mclk);
      rd_off(1'b1);
      sleep_request = 1'b0;
      repeat (4) @(negedge mclk);
   endtask : s_async

   task automatic wrap_up;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   // Main sequence
   initial begin
      repeat (20) @(negedge mclk);
      cmp_bit(data_oe, 1'b0);
      rst = 1'b0;
      @(negedge mclk);
      cmp_bit(wbuf_ready, 1'b1);
      s_write();
      s_burst();
      rd(2'h1, 1'b1, 1'b0, 3);
      s_proc();
      s_ce_pipe();
      rd_off(1'b0);
      s_async();
      wrap_up();
   end

   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #400000;
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end
endmodule : testbench

bind pbsp_top pbsp_port_monitor #(.BYTES(BYTES), .BYTE_W(BYTE_W)) i_mon (
   .mclk, .rst, .processor_addr_strobe_n, .controller_addr_strobe_n,
   .burst_advance_n, .pipelined_chip_enable_n, .depth_chip_enable_hi,
   .depth_chip_enable_lo_n, .byte_write_select_n, .byte_write_enable_n,
   .global_write_n, .output_enable_n, .sleep_request, .data_out, .data_oe,
   .wbuf_ready);

`default_nettype wire
